/* File: rtl/fac_top.sv */
// flash access wait-state sequencer and program/erase control for a multi-module array
// assumes the array macro answers arr_rdata combinationally for arr_addr on clk_sys,
// and the core holds a read request until it sees rd_ready
// Notes on behaviour
// - array leaves reset with every sector erased and nothing protected.
// - program/erase allowed beside one read module; the reading module is never the target (a read taken in the request's cycle is not checked).
// - the fourth module may be programmed/erased while any other module is read.
// - sector or page erase ends within 8.0 ms, typically 7 ms.
// - page program ends within 3.5 ms, typically 3 ms.
// - durations timed on the flash clock plus a few system clock cycles.
// - wait states hit non-sequential reads fully, sequential ones only partly.
// - cacheable reads: one extra wait on a miss, none on a hit.
`timescale 1ns/1ps
module fac_top #(
    parameter int ERASE_TICKS = fac_pkg::ERASE_TICKS,
    parameter int PROG_TICKS  = fac_pkg::PROG_TICKS,
    parameter int NUM_MODULES = fac_pkg::NUM_MODULES
) (
    input  wire logic                       clk_sys,               // system clock, 200 MHz
    input  wire logic                       resetn,                // application reset, active low
    input  wire logic                       fl_clk_src,            // internal flash clock, asynchronous
    input  wire logic [fac_pkg::WAIT_W-1:0] flash_wait_count,      // configured wait states
    input  wire logic                       wait_extension,        // one more wait at high clock
    input  wire logic                       safe_wait_after_reset, // keep extension after reset
    input  wire logic                       rd_req,                // read request
    input  wire logic [fac_pkg::ADDR_W-1:0] rd_addr,               // read address
    input  wire logic                       rd_seq,                // sequential to previous read
    input  wire logic                       rd_cacheable,          // through cacheable window
    input  wire logic                       cache_hit,             // cache holds the word
    output logic                            rd_ready,              // request taken this cycle
    output logic                            rd_valid,              // read data valid pulse
    output logic [fac_pkg::DATA_W-1:0]      rd_data,               // read data
    output logic [fac_pkg::ADDR_W-1:0]      arr_addr,              // address to the array
    input  wire logic [fac_pkg::DATA_W-1:0] arr_rdata,             // array data
    input  wire logic                       pe_req,                // program/erase request
    input  wire logic                       pe_erase,              // 1 erase, 0 program
    input  wire logic [fac_pkg::MOD_W-1:0]  pe_module,             // target module
    output logic                            pe_ack,                // request accepted pulse
    output logic                            pe_refused,            // request refused pulse
    output logic [NUM_MODULES-1:0]          module_busy,           // operation running
    output logic [NUM_MODULES-1:0]          module_blank,          // module holds erased data
    output logic [NUM_MODULES-1:0]          pe_done                // completion pulse per module
);
    localparam int MW = fac_pkg::MOD_W;
    localparam int WW = fac_pkg::WAIT_W;
    localparam int LW = fac_pkg::LAT_W;

    if (NUM_MODULES < 1 || NUM_MODULES > (1 << MW) || NUM_MODULES <= fac_pkg::DATA_MODULE) begin : g_chk
        $error("fac_top: unsupported module count");
    end

    // module select decoding, used for reads and for checks
    function automatic logic [MW-1:0] mod_of(input logic [fac_pkg::ADDR_W-1:0] a);
        return a[fac_pkg::MOD_LSB +: MW];
    endfunction

    function automatic int unsigned ones(input logic [NUM_MODULES-1:0] v);
        int unsigned n;
        n = 0;
        for (int i = 0; i < NUM_MODULES; i++) begin
            n += v[i];
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and flash clock synchronisers
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [1:0] fl_sync_q;
    logic       fl_prev_q;
    logic       fl_tick;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // only the second stage feeds the edge detector
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fl_sync_q <= 2'h0;
            fl_prev_q <= 1'b0;
        end else begin
            fl_sync_q <= {fl_sync_q[0], fl_clk_src};
            fl_prev_q <= fl_sync_q[1];
        end
    end
    assign fl_tick = fl_sync_q[1] & ~fl_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // extension floor caught once after release; the flag is cleared by this reset
    logic ext_floor_q;
    logic floor_taken_q;
    logic ext_eff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_floor_q   <= 1'b0;
            floor_taken_q <= 1'b0;
        end else if (!floor_taken_q) begin
            ext_floor_q   <= safe_wait_after_reset;
            floor_taken_q <= 1'b1;
        end
    end
    // a fast clock survives the reset without a too-short default
    assign ext_eff = wait_extension | ext_floor_q;

    ////////////////////////////////////////////////////////////////////////////
    // read sequencer
    fac_pkg::fac_rd_state_t   rd_state_q;
    logic [MW-1:0]            rd_mod_q;
    logic [WW:0]              wcnt_q;
    logic [WW:0]              base_w;
    logic [WW:0]              wait_d;
    logic                     rd_acc;
    logic [fac_pkg::DATA_W-1:0] rd_data_q;
    logic [MW-1:0]            acc_mod;
    logic [fac_pkg::ADDR_W-1:0] addr_q;

    assign rd_ready = (rd_state_q == fac_pkg::RD_IDLE);
    assign rd_acc   = rd_req && rd_ready;
    assign rd_valid = (rd_state_q == fac_pkg::RD_DATA);
    assign rd_data  = rd_data_q;
    assign acc_mod  = mod_of(rd_addr);
    // idle shows the request itself, so a zero-wait read captures its own word
    assign arr_addr = rd_ready ? rd_addr : addr_q;
    assign base_w   = {1'b0, flash_wait_count} + {{WW{1'b0}}, ext_eff};

    // wait cycles chosen per access kind
    always_comb begin
        if (rd_cacheable) begin
            wait_d = cache_hit ? '0 : base_w + (WW+1)'(1);
        end else if (rd_seq) begin
            wait_d = base_w >> 1;
        end else begin
            wait_d = base_w;
        end
    end

    // a read to a busy module stalls until its operation ends
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_q <= fac_pkg::RD_IDLE;
            rd_mod_q   <= '0;
            wcnt_q     <= '0;
            addr_q     <= '0;
        end else begin
            unique case (rd_state_q)
                fac_pkg::RD_IDLE: begin
                    if (rd_acc) begin
                        rd_mod_q <= acc_mod;
                        addr_q   <= rd_addr;
                        wcnt_q   <= wait_d;
                        if (wait_d != '0 || module_busy[acc_mod]) begin
                            rd_state_q <= fac_pkg::RD_WAIT;
                        end else begin
                            rd_state_q <= fac_pkg::RD_DATA;
                        end
                    end
                end
                fac_pkg::RD_WAIT: begin
                    if (wcnt_q != '0) begin
                        wcnt_q <= wcnt_q - (WW+1)'(1);
                    end
                    if (wcnt_q <= (WW+1)'(1) && !module_busy[rd_mod_q]) begin
                        rd_state_q <= fac_pkg::RD_DATA;
                    end
                end
                fac_pkg::RD_DATA: begin
                    rd_state_q <= fac_pkg::RD_IDLE;
                end
                default: rd_state_q <= fac_pkg::RD_IDLE;
            endcase
        end
    end

    // data captured on the step into the data cycle; blank modules read as erased
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= '0;
        end else if ((rd_state_q == fac_pkg::RD_IDLE && rd_acc && wait_d == '0 && !module_busy[acc_mod]) ||
                     (rd_state_q == fac_pkg::RD_WAIT && wcnt_q <= (WW+1)'(1) && !module_busy[rd_mod_q])) begin
            rd_data_q <= module_blank[rd_state_q == fac_pkg::RD_IDLE ? acc_mod : rd_mod_q] ?
                         fac_pkg::ERASED_WORD : arr_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program/erase admission
    logic [NUM_MODULES-1:0] rd_mask_q;
    logic [NUM_MODULES-1:0] nondata_busy;
    logic                   multi_read;
    logic                   pe_ok;
    logic                   pe_ack_q;
    logic                   pe_ref_q;
    logic [NUM_MODULES-1:0] start_vec;

    // modules read while any operation runs; cleared once all are idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_mask_q <= '0;
        end else if (module_busy == '0 && !pe_ack_q) begin
            rd_mask_q <= rd_acc ? (NUM_MODULES'(1) << acc_mod) : '0;
        end else if (rd_acc) begin
            rd_mask_q <= rd_mask_q | (NUM_MODULES'(1) << acc_mod);
        end
    end

    always_comb begin
        nondata_busy = module_busy;
        nondata_busy[fac_pkg::DATA_MODULE] = 1'b0;
    end
    assign multi_read = ones(rd_mask_q) > 1;

    // a module whose read is already under way is never a target; the data module ignores the parallel limit
    assign pe_ok = (int'(pe_module) < NUM_MODULES) && !module_busy[pe_module] &&
                   !((rd_state_q != fac_pkg::RD_IDLE || rd_mask_q[pe_module]) && rd_mod_q == pe_module) &&
                   ((pe_module == MW'(fac_pkg::DATA_MODULE)) ||
                    (ones(nondata_busy) < (multi_read ? fac_pkg::MAX_PAR_MULTI : fac_pkg::MAX_PARALLEL)));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pe_ack_q <= 1'b0;
            pe_ref_q <= 1'b0;
        end else begin
            pe_ack_q <= pe_req && pe_ok;
            pe_ref_q <= pe_req && !pe_ok;
        end
    end
    assign pe_ack     = pe_ack_q;
    assign pe_refused = pe_ref_q;
    assign start_vec  = (pe_req && pe_ok) ? (NUM_MODULES'(1) << pe_module) : '0;

    ////////////////////////////////////////////////////////////////////////////
    // per-module timers and erased-state tracking
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
        fac_op_timer #(
            .ERASE_TICKS (ERASE_TICKS),
            .PROG_TICKS  (PROG_TICKS),
            .OVH_CYC     (fac_pkg::OVERHEAD_CYC)
        ) u_timer (
            .clk_sys  (clk_sys),
            .rst_n    (rst_n),
            .start    (start_vec[m]),
            .is_erase (pe_erase),
            .fl_tick  (fl_tick),
            .busy     (module_busy[m]),
            .done     (pe_done[m])
        );

        // shipped erased; programming spoils it, a finished erase restores it
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                module_blank[m] <= 1'b1;
            end else if (start_vec[m] && !pe_erase) begin
                module_blank[m] <= 1'b0;
            end else if (pe_done[m] && g_mod[m].u_timer.erase_q) begin
                module_blank[m] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // helper: cycles from acceptance to data, and the kind of access
    logic [LW-1:0] lat_q;
    logic [WW:0]   base_q;
    logic [1:0]    kind_q; // 0 plain, 1 sequential, 2 hit, 3 miss
    logic          stall_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lat_q   <= '0;
            base_q  <= '0;
            kind_q  <= 2'h0;
            stall_q <= 1'b0;
        end else if (rd_acc) begin
            lat_q   <= LW'(1);
            base_q  <= {1'b0, flash_wait_count} + {{WW{1'b0}}, ext_eff};
            kind_q  <= rd_cacheable ? {1'b1, ~cache_hit} : {1'b0, rd_seq};
            stall_q <= module_busy[acc_mod];
        end else if (!rd_ready) begin
            lat_q <= lat_q + LW'(1);
        end
    end

    AST_BLANK_AFTER_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rst_n) |-> (&module_blank && module_busy == '0))
        else $error("array not blank after reset");

    AST_READ_MOD_PROTECTED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pe_req && rd_state_q != fac_pkg::RD_IDLE && pe_module == rd_mod_q) |=> (pe_refused && !pe_ack))
        else $error("reading module accepted as target");

    AST_BUSY_STALLS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_state_q == fac_pkg::RD_WAIT && module_busy[rd_mod_q]) |=> !rd_valid)
        else $error("read returned from a busy module");

    AST_DATA_MOD_FREE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pe_req && pe_module == MW'(fac_pkg::DATA_MODULE) && !module_busy[fac_pkg::DATA_MODULE] &&
         rd_state_q == fac_pkg::RD_IDLE && !rd_mask_q[fac_pkg::DATA_MODULE]) |=> pe_ack)
        else $error("data module refused");

    AST_PLAIN_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_valid && kind_q == 2'h0 && !stall_q) |-> (lat_q == LW'(base_q) + LW'(1)))
        else $error("non-sequential wait wrong");

    AST_SEQ_PARTIAL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_valid && kind_q == 2'h1 && !stall_q) |-> (lat_q == LW'(base_q >> 1) + LW'(1)))
        else $error("sequential wait wrong");

    AST_CACHE_HIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_acc && rd_cacheable && cache_hit && !module_busy[acc_mod]) |=> rd_valid)
        else $error("cache hit waited");

    AST_CACHE_MISS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_valid && kind_q == 2'h3 && !stall_q) |-> (lat_q == LW'(base_q) + LW'(2)))
        else $error("cache miss wait wrong");

endmodule

/* File: pkg/fac_pkg.sv */
// shared constants and types for the flash access and wait-state control block
// assumes one system clock at 200 MHz and a free-running internal flash clock source
package fac_pkg;

    // clock rates in kHz
    localparam int SYS_CLK_KHZ   = 200000;
    localparam int FL_CLK_KHZ    = 5000;

    // operation durations in microseconds, typical and longest
    localparam int ERASE_TYP_US  = 7000;
    localparam int ERASE_MAX_US  = 8000;
    localparam int PROG_TYP_US   = 3000;
    localparam int PROG_MAX_US   = 3500;

    // durations counted in flash clock ticks; the longest time rounds down
    localparam int ERASE_TICKS     = (ERASE_TYP_US * FL_CLK_KHZ) / 1000;
    localparam int ERASE_MAX_TICKS = (ERASE_MAX_US * FL_CLK_KHZ) / 1000;
    localparam int PROG_TICKS      = (PROG_TYP_US * FL_CLK_KHZ) / 1000;
    localparam int PROG_MAX_TICKS  = (PROG_MAX_US * FL_CLK_KHZ) / 1000;

    // system clock cycles the control machine adds after each operation
    localparam int OVERHEAD_CYC  = 4;

    // array organisation
    localparam int NUM_MODULES   = 5;
    localparam int MOD_W         = 3;
    localparam int DATA_MODULE   = 3;   // fourth module, data storage
    localparam int MAX_PARALLEL  = 5;   // parallel program/erase with one read module
    localparam int MAX_PAR_MULTI = 1;   // parallel limit once more modules are read
    localparam int ADDR_W        = 24;
    localparam int MOD_LSB       = 18;  // module select field in the read address
    localparam int DATA_W        = 16;
    localparam int WAIT_W        = 4;
    localparam int LAT_W         = 6;

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

    // read sequencer states
    typedef enum logic [2:0] {
        RD_IDLE = 3'h1,
        RD_WAIT = 3'h2,
        RD_DATA = 3'h4
    } fac_rd_state_t;

endpackage

/* File: rtl/fac_op_timer.sv */
// one program/erase duration timer for a single flash module
// assumes fl_tick is a one-cycle pulse per internal flash clock period, already synchronised
`timescale 1ns/1ps
module fac_op_timer #(
    parameter int ERASE_TICKS = fac_pkg::ERASE_TICKS,
    parameter int PROG_TICKS  = fac_pkg::PROG_TICKS,
    parameter int OVH_CYC     = fac_pkg::OVERHEAD_CYC
) (
    input  wire logic clk_sys,   // system clock
    input  wire logic rst_n,     // synchronised reset, active low
    input  wire logic start,     // start pulse, taken only while idle
    input  wire logic is_erase,  // 1 erase, 0 page program
    input  wire logic fl_tick,   // flash clock tick pulse
    output logic      busy,      // operation running
    output logic      done       // one-cycle completion pulse
);
    localparam int CNT_W   = $clog2(((ERASE_TICKS > PROG_TICKS) ? ERASE_TICKS : PROG_TICKS) + 1);
    localparam int OVH_W   = $clog2(OVH_CYC + 1);
    localparam int OVH_DLY = OVH_CYC - 1;

    if (ERASE_TICKS < 1 || PROG_TICKS < 1 || OVH_CYC < 1) begin : g_chk
        $error("fac_op_timer: counts must be at least one");
    end

    logic             tick_ph_q;
    logic             ovh_ph_q;
    logic [CNT_W-1:0] cnt_q;
    logic [OVH_W-1:0] ovh_q;
    logic             done_q;
    logic             erase_q;
    logic [CNT_W-1:0] seen_q;

    assign busy = tick_ph_q | ovh_ph_q;
    assign done = done_q;

    ////////////////////////////////////////////////////////////////////////////
    // duration counted on the flash clock, then the fixed overhead on clk_sys
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_ph_q <= 1'b0;
            ovh_ph_q  <= 1'b0;
            cnt_q     <= '0;
            ovh_q     <= '0;
            done_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy) begin
                tick_ph_q <= 1'b1;
                cnt_q     <= is_erase ? CNT_W'(ERASE_TICKS) : CNT_W'(PROG_TICKS);
            end else if (tick_ph_q && fl_tick) begin
                if (cnt_q == CNT_W'(1)) begin
                    tick_ph_q <= 1'b0;
                    ovh_ph_q  <= 1'b1;
                    ovh_q     <= OVH_W'(OVH_CYC);
                end else begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
            end else if (ovh_ph_q) begin
                if (ovh_q == OVH_W'(1)) begin
                    ovh_ph_q <= 1'b0;
                    done_q   <= 1'b1;
                end else begin
                    ovh_q <= ovh_q - OVH_W'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // helper: ticks actually seen during the current operation
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_q  <= '0;
            erase_q <= 1'b0;
        end else if (start && !busy) begin
            seen_q  <= '0;
            erase_q <= is_erase;
        end else if (tick_ph_q && fl_tick) begin
            seen_q <= seen_q + CNT_W'(1);
        end
    end

    AST_ERASE_TIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (done && erase_q) |-> (seen_q == CNT_W'(ERASE_TICKS)))
        else $error("erase did not last its tick count");

    AST_PROG_TIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (done && !erase_q) |-> (seen_q == CNT_W'(PROG_TICKS)))
        else $error("program did not last its tick count");

    AST_OVERHEAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ovh_ph_q) |-> (busy && !done)[*1] ##[OVH_DLY:OVH_DLY] (ovh_ph_q ##1 done))
        else $error("overhead cycles wrong");

endmodule

/* File: testbench/fac_core_model.sv */
// processor core model: one read per start pulse, timing the answer in clock edges
// assumes the block's read port runs on the same clk_sys and rd_ready is combinational
`timescale 1ns/1ps
module fac_core_model (
    input  wire logic                       clk_sys,      // system clock
    input  wire logic                       start,        // issue one read
    input  wire logic [fac_pkg::ADDR_W-1:0] a_addr,       // address to read
    input  wire logic                       a_seq,        // sequential flag
    input  wire logic                       a_cach,       // cacheable flag
    input  wire logic                       a_hit,        // cache hit flag
    input  wire logic                       rd_ready,     // block takes request
    input  wire logic                       rd_valid,     // data pulse
    input  wire logic [fac_pkg::DATA_W-1:0] rd_data,      // read data
    output logic                            rd_req,       // request
    output logic [fac_pkg::ADDR_W-1:0]      rd_addr,      // request address
    output logic                            rd_seq,       // sequential
    output logic                            rd_cacheable, // cacheable window
    output logic                            cache_hit,    // hit
    output logic                            done,         // answer seen pulse
    output logic [7:0]                      lat,          // edges from take to data
    output logic [fac_pkg::DATA_W-1:0]      data          // data seen
);
    logic [7:0] cnt_q;
    initial {rd_req, rd_addr, rd_seq, rd_cacheable, cache_hit, done} = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // hold request and qualifiers until taken; released address is inverted so a
    // design that reads it late sees garbage rather than a lucky stale value
    always @(posedge clk_sys) begin
        done <= 1'b0;
        if (start) begin
            {rd_req, rd_addr, rd_seq, rd_cacheable, cache_hit} <= {1'b1, a_addr, a_seq, a_cach, a_hit};
        end else if (rd_req && rd_ready) begin
            {rd_req, rd_addr, rd_seq} <= {1'b0, ~rd_addr, ~rd_seq};
            cnt_q <= 8'h01;
        end else if (rd_valid) begin
            {done, lat, data} <= {1'b1, cnt_q, rd_data};
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the flash wait-state and program/erase block
// assumes short erase/program tick counts and a flash clock of 8 system cycles
`timescale 1ns/1ps
module testbench;
    localparam int ET = 5;
    localparam int PT = 3;
    logic clk_sys = 0, resetn = 0, fl_clk_src = 0, safe = 0, ext = 0, start = 0, c_seq = 0, c_cach = 0, c_hit = 0;
    logic pe_req = 0, pe_erase = 0, pe_ack, pe_refused, rd_req, rd_seq, rd_cach, hit, rd_ready, rd_valid, c_done;
    logic [2:0] pe_module = 0;
    logic [3:0] wcnt = 4'h4;
    logic [4:0] busy, blank, pe_done;
    logic [23:0] c_addr = 0, rd_addr, arr_addr;
    logic [15:0] rd_data, arr_rdata, c_data;
    logic [7:0] c_lat;
    logic a, r;
    int err_total = 0, checks = 0, cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    always #20 fl_clk_src = ~fl_clk_src;
    assign arr_rdata = arr_addr[15:0] ^ 16'h5A5A; // array macro stand-in
    fac_top #(.ERASE_TICKS(ET), .PROG_TICKS(PT)) fac_top_inst (.clk_sys(clk_sys), .resetn(resetn),
        .fl_clk_src(fl_clk_src), .flash_wait_count(wcnt), .wait_extension(ext), .safe_wait_after_reset(safe),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_seq(rd_seq), .rd_cacheable(rd_cach), .cache_hit(hit),
        .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .arr_addr(arr_addr), .arr_rdata(arr_rdata),
        .pe_req(pe_req), .pe_erase(pe_erase), .pe_module(pe_module), .pe_ack(pe_ack), .pe_refused(pe_refused),
        .module_busy(busy), .module_blank(blank), .pe_done(pe_done));
    fac_core_model fac_core_model_inst (.clk_sys(clk_sys), .start(start), .a_addr(c_addr), .a_seq(c_seq),
        .a_cach(c_cach), .a_hit(c_hit), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_seq(rd_seq), .rd_cacheable(rd_cach), .cache_hit(hit),
        .done(c_done), .lat(c_lat), .data(c_data));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // reset with the safe-after-reset level applied before release
    task do_reset(input logic s);
        resetn <= 1'b0;
        safe <= s;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task rd_go(input logic [23:0] ad, input logic s, input logic c, input logic h);
        @(posedge clk_sys);
        {start, c_addr, c_seq, c_cach, c_hit} <= {1'b1, ad, s, c, h};
        @(posedge clk_sys);
        start <= 1'b0;
    endtask
    task rd_wait;
        int n;
        n = 0;
        while (c_done !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("rd_done", 1, c_done);
    endtask
    task pe(input logic er, input logic [2:0] m);
        @(posedge clk_sys);
        {pe_req, pe_erase, pe_module} <= {1'b1, er, m};
        @(posedge clk_sys);
        pe_req <= 1'b0;
        #1 {a, r} = {pe_ack, pe_refused};
    endtask
    // cycles from acceptance to the completion pulse, inside a window around ticks*8+overhead
    task done_in(input int m, input int t);
        int n;
        n = 0;
        while (pe_done[m] !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("op_time", 1, n >= (t - 1) * 8 && n <= t * 8 + 16);
        chk("busy_end", 0, busy[m]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // wait counts 1 to 4 with and without extension, in all four access kinds
    task t_waits;
        for (int i = 1; i <= 4; i++) begin
            for (int e = 0; e <= 1; e++) begin
                wcnt <= i[3:0];
                ext <= e[0];
                rd_go(24'h000010, 0, 0, 0); rd_wait();
                chk("lat_nonseq", i + e + 1, c_lat);
                chk("blank_data", 16'hFFFF, c_data);
                rd_go(24'h000012, 1, 0, 0); rd_wait();
                chk("lat_seq", (i + e) / 2 + 1, c_lat);
                rd_go(24'h000014, 0, 1, 1); rd_wait();
                chk("lat_hit", 1, c_lat);
                rd_go(24'h000016, 0, 1, 0); rd_wait();
                chk("lat_miss", i + e + 2, c_lat);
            end
        end
    endtask
    // program then erase one module, with blank state and data followed
    task t_prog_erase;
        pe(0, 3'd1);
        chk("prog_ack", 1, a);
        chk("prog_blank", 0, blank[1]);
        done_in(1, PT);
        rd_go(24'h040020, 0, 0, 0); rd_wait();
        chk("prog_data", 16'h5A7A, c_data);
        rd_go(24'h040022, 0, 1, 1);
        rd_wait();
        chk("hit_data", 16'h5A78, c_data);
        pe(1, 3'd1);
        done_in(1, ET);
        @(posedge clk_sys);
        #1 chk("erase_blank", 1, blank[1]);
    endtask
    // refusals around reads in progress and several read modules
    task t_refuse;
        rd_go(24'h080000, 0, 0, 0);
        pe(0, 3'd2);
        chk("read_target", 1, r);
        rd_wait();
        pe(0, 3'd1);
        rd_go(24'h000004, 0, 0, 0); rd_wait();
        rd_go(24'h100004, 0, 0, 0); rd_wait();
        pe(0, 3'd2);
        chk("multi_read", 1, r);
        pe(0, 3'd3);
        chk("data_module", 1, a);
        repeat (200) @(posedge clk_sys);
        chk("all_idle", 0, busy);
    endtask
    // safe flag keeps the extension on after a reset
    task t_safe;
        do_reset(1);
        wcnt <= 4'h2;
        ext <= 1'b0;
        rd_go(24'h000000, 0, 0, 0); rd_wait();
        chk("safe_lat", 4, c_lat);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        do_reset(0);
        chk("reset_blank", 5'h1F, blank);
        t_waits();
        t_prog_erase();
        t_refuse();
        t_safe();
        stop_test();
    end
endmodule
